// ==== hdl/scs_pkg.sv ====
// constants and types of the system clock source select block
package scs_pkg;

  // ----------------------------------------------------------------
  // rates and oscillator models
  // ----------------------------------------------------------------
  localparam longint REF_HZ = 10000000;
  localparam longint FAST_RC_HZ = 7370000;
  localparam longint LOW_POWER_RC_HZ = 32768;
  localparam longint INSTR_MAX_HZ = 40000000;
  localparam int NCO_BITS = 16;
  localparam logic [15:0] FAST_RC_INC = 16'((FAST_RC_HZ * 65536) / REF_HZ);
  localparam logic [15:0] LOW_POWER_RC_INC = 16'((LOW_POWER_RC_HZ * 65536) / REF_HZ);
  localparam logic [15:0] TUNE_STEP = 16'(FAST_RC_INC >> 8);
  localparam logic [2:0] FAIL_WINDOW_TICKS = 3'h4;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OSC_CTRL_OFS = 12'h000;
  localparam logic [11:0] CLK_DIV_OFS = 12'h004;
  localparam logic [11:0] RC_TUNE_OFS = 12'h008;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CUR_OSC_LSB = 12;
  localparam int NEW_OSC_LSB = 8;
  localparam int CLOCK_LOCK_BIT = 7;
  localparam int PLL_LOCK_BIT = 5;
  localparam int CLOCK_FAIL_BIT = 3;
  localparam int LP_OSC_EN_BIT = 1;
  localparam int OSC_SWITCH_BIT = 0;
  localparam int DOZE_RATIO_LSB = 12;
  localparam int DOZE_EN_BIT = 11;
  localparam int POSTSCALE_LSB = 8;
  localparam int TUNE_BITS = 6;

  // ----------------------------------------------------------------
  // oscillator selections and primary modes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_FAST_RC = 3'h0;
  localparam logic [2:0] SEL_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SEL_PRIMARY = 3'h2;
  localparam logic [2:0] SEL_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SEL_SECONDARY = 3'h4;
  localparam logic [2:0] SEL_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] SEL_FAST_RC_DIV16 = 3'h6;
  localparam logic [2:0] SEL_FAST_RC_DIVN = 3'h7;
  localparam logic [1:0] MODE_EXTERNAL = 2'h0;
  localparam logic [1:0] MODE_CRYSTAL = 2'h1;
  localparam logic [1:0] MODE_HS_CRYSTAL = 2'h2;
  localparam logic [7:0] DIV16_MASK = 8'h0f;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] DOZE_RESET = 3'h0;
  localparam logic [2:0] POSTSCALE_RESET = 3'h0;
  localparam logic [5:0] TUNE_RESET = 6'h00;

  typedef struct packed {
    logic [2:0] dozeRatio;
    logic dozeEn;
    logic [2:0] postscale;
  } scs_div_t;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT_SRC, SW_WAIT_LOW} scs_sw_state_t;

endpackage

// ==== hdl/scs_clock_select.sv ====
// system clock source selection, dividers, fail monitor and register slave

// Functional notes
// - eight system clock options, selected by a three-bit code.
// - fast internal RC nominal 7.37 MHz before postscale or PLL.
// - tuning register shifts the fast internal RC frequency.
// - fast RC postscaler 1:2 to 1:256, field bits 10:8 of divisor register.
// - primary supports crystal, high-speed crystal and external clock from input pin.
// - secondary low-power oscillator runs a 32.768 kHz crystal on own pins.
// - low-power RC also references watchdog and clock-fail monitor.
// - only fast RC and primary feed the PLL.
// - power-on source from three-bit select and two-bit mode configuration fields.
// - unprogrammed configuration gives a fast internal RC selection.
// - configuration fields encode twelve clock modes.
// - oscillator or PLL output divided by 2 gives instruction and peripheral clocks.
// - instruction clocks up to 40 MHz supported; software keeps within it.
// - peripheral equals instruction clock except doze; doze ratio resets 1:1.
// - clock-fail monitor detects lost clock and falls back to fast RC.
// - software switches source at run time via oscillator control register.
// - select codes 111 divN, 110 div16, 101 LOW_POWER_INTERNAL_RC, 100 secondary, 011..000 as listed.
// - primary mode 10 high-speed crystal, 01 crystal, 00 external clock.
module scs_clock_select
  import scs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration memory fields
  input wire logic [2:0] initialOscSelect,
  input wire logic [1:0] primaryOscModeSelect,
  // oscillator pins and pll
  input wire logic primaryOscInPin,
  output logic primaryOscOutPin,
  output logic primaryOscOutEn,
  input wire logic secondaryOscInPin,
  output logic secondaryOscOutPin,
  output logic secondaryOscOutEn,
  input wire logic pllClkIn,
  input wire logic pllLockIn,
  output logic pllRefTick,
  // derived clocks
  output logic instrClk,
  output logic peripheralClk,
  output logic watchdogRefTick
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pinRaw;
  logic [3:0] syncA_q;
  logic [3:0] syncB_q;
  logic [3:0] syncC_q;
  assign pinRaw = {pllLockIn, pllClkIn, secondaryOscInPin, primaryOscInPin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          syncA_q[gi] <= 1'b0;
          syncB_q[gi] <= 1'b0;
          syncC_q[gi] <= 1'b0;
        end else begin
          syncA_q[gi] <= pinRaw[gi];
          syncB_q[gi] <= syncA_q[gi];
          syncC_q[gi] <= syncB_q[gi];
        end
      end
    end
  endgenerate

  logic lowPowerOscEn_q;
  logic secondaryRun;
  logic primaryTick;
  logic secondaryTick;
  logic pllTick;
  logic pllLocked;
  // every primary mode clocks from the input pin
  assign primaryTick = syncB_q[0] & ~syncC_q[0];
  // secondary counted only while its driver runs
  assign secondaryTick = secondaryRun & syncB_q[1] & ~syncC_q[1];
  assign pllTick = syncB_q[2] & ~syncC_q[2];
  assign pllLocked = syncB_q[3];

  // ----------------------------------------------------------------
  // internal rc oscillators
  // ----------------------------------------------------------------
  logic [5:0] tune_q;
  logic [15:0] frcAcc_q;
  logic [15:0] lprcAcc_q;
  logic [15:0] tuneOffset;
  logic [15:0] frcInc;
  logic [16:0] frcSum;
  logic [16:0] lprcSum;
  logic frcTick;
  logic lprcTick;

  // signed tuning offset on the nominal increment
  assign tuneOffset = 16'($signed(tune_q) * $signed({1'b0, TUNE_STEP}));
  // accumulator overflows at the tuned fast rc rate
  assign frcInc = FAST_RC_INC + tuneOffset;
  assign frcSum = {1'b0, frcAcc_q} + {1'b0, frcInc};
  assign lprcSum = {1'b0, lprcAcc_q} + {1'b0, LOW_POWER_RC_INC};
  assign frcTick = frcSum[16];
  assign lprcTick = lprcSum[16];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      frcAcc_q <= 16'h0000;
      lprcAcc_q <= 16'h0000;
    end else begin
      frcAcc_q <= frcSum[15:0];
      lprcAcc_q <= lprcSum[15:0];
    end
  end

  // ----------------------------------------------------------------
  // fast rc postscaler
  // ----------------------------------------------------------------
  scs_div_t div_q;
  logic [7:0] postCnt_q;
  logic [7:0] postMask;
  logic frcDivTick;
  logic frcDiv16Tick;

  // divide by 2 to the power (field + 1)
  assign postMask = 8'((9'h002 << div_q.postscale) - 9'h001);
  assign frcDivTick = frcTick & ((postCnt_q & postMask) == postMask);
  assign frcDiv16Tick = frcTick & ((postCnt_q & DIV16_MASK) == DIV16_MASK);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      postCnt_q <= 8'h00;
    end else if (frcTick) begin
      postCnt_q <= postCnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  logic [2:0] curOsc_q;
  logic [2:0] newOsc_q;
  logic [1:0] primaryMode_q;
  logic [7:0] tickBySel;
  logic curTick;
  logic newTick;
  logic newIsPll;
  logic newReady;

  // one tick source per selection code
  // code order of the selection field
  assign tickBySel = {frcDivTick, frcDiv16Tick, lprcTick, secondaryTick,
                      pllTick, primaryTick, pllTick, frcTick};
  assign curTick = tickBySel[curOsc_q];
  assign newTick = tickBySel[newOsc_q];
  assign newIsPll = (newOsc_q == SEL_FAST_RC_PLL) || (newOsc_q == SEL_PRIMARY_PLL);
  assign newReady = newTick & (~newIsPll | pllLocked);
  assign secondaryRun = lowPowerOscEn_q | (curOsc_q == SEL_SECONDARY)
                        | (newOsc_q == SEL_SECONDARY);

  // ----------------------------------------------------------------
  // clock fail monitor
  // ----------------------------------------------------------------
  logic [2:0] failWin_q;
  logic seenTick_q;
  logic clockFail_q;
  logic failEvent;

  // window paced by low-power rc ticks
  // no source edge in a full window means a lost clock
  assign failEvent = lprcTick && (failWin_q == FAIL_WINDOW_TICKS - 3'h1) && !seenTick_q
                     && !curTick && (curOsc_q != SEL_FAST_RC);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      failWin_q <= 3'h0;
      seenTick_q <= 1'b0;
    end else if (lprcTick && failWin_q == FAIL_WINDOW_TICKS - 3'h1) begin
      failWin_q <= 3'h0;
      seenTick_q <= 1'b0;
    end else begin
      failWin_q <= failWin_q + {2'h0, lprcTick};
      seenTick_q <= seenTick_q | curTick;
    end
  end

  // ----------------------------------------------------------------
  // register access decode
  // ----------------------------------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic clockLock_q;
  logic oscSwitch_q;
  logic cfgLoaded_q;
  logic hitCtrl;
  logic hitDiv;
  logic hitTune;
  logic hitAny;
  logic accessEdge;
  logic wrCtrl;
  logic wrDiv;
  logic wrTune;
  logic [31:0] readMux;
  logic illegalSwitch;
  logic switchReq;

  assign hitCtrl = (paddr == OSC_CTRL_OFS);
  assign hitDiv = (paddr == CLK_DIV_OFS);
  assign hitTune = (paddr == RC_TUNE_OFS);
  assign hitAny = hitCtrl | hitDiv | hitTune;
  assign accessEdge = psel & penable & pready_q;
  assign wrCtrl = accessEdge & pwrite & hitCtrl;
  assign wrDiv = accessEdge & pwrite & hitDiv;
  assign wrTune = accessEdge & pwrite & hitTune;
  // a direct hop between the two pll modes is dropped
  assign illegalSwitch = ((curOsc_q == SEL_PRIMARY_PLL)
                          && (pwdata[NEW_OSC_LSB +: 3] == SEL_FAST_RC_PLL))
                         || ((curOsc_q == SEL_FAST_RC_PLL)
                          && (pwdata[NEW_OSC_LSB +: 3] == SEL_PRIMARY_PLL));
  // run-time switch request from the control register
  assign switchReq = wrCtrl & pwdata[OSC_SWITCH_BIT] & ~clockLock_q & ~illegalSwitch
                     & ~oscSwitch_q;
  assign readMux = hitCtrl ? {17'h0, curOsc_q, 1'b0, newOsc_q, clockLock_q, 1'b0,
                              pllLocked, 1'b0, clockFail_q, 1'b0, lowPowerOscEn_q,
                              oscSwitch_q}
                 : hitDiv ? {17'h0, div_q.dozeRatio, div_q.dozeEn, div_q.postscale, 8'h00}
                 : hitTune ? {26'h0, tune_q}
                 : 32'h0;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hitAny;
      prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? readMux : 32'h0;
    end
  end

  // doze ratio comes out of reset at 1:1
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_q <= '{dozeRatio: DOZE_RESET, dozeEn: 1'b0, postscale: POSTSCALE_RESET};
      tune_q <= TUNE_RESET;
    end else begin
      if (wrDiv) begin
        div_q <= '{dozeRatio: pwdata[DOZE_RATIO_LSB +: 3], dozeEn: pwdata[DOZE_EN_BIT],
                   postscale: pwdata[POSTSCALE_LSB +: 3]};
      end
      if (wrTune) begin
        tune_q <= pwdata[TUNE_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // control register and switch sequencer
  // ----------------------------------------------------------------
  scs_sw_state_t swState_q;
  logic instrClk_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfgLoaded_q <= 1'b0;
      curOsc_q <= SEL_FAST_RC;
      newOsc_q <= SEL_FAST_RC;
      primaryMode_q <= MODE_EXTERNAL;
      clockLock_q <= 1'b0;
      clockFail_q <= 1'b0;
      lowPowerOscEn_q <= 1'b0;
      oscSwitch_q <= 1'b0;
      swState_q <= SW_IDLE;
    end else if (!cfgLoaded_q) begin
      // configuration fields caught after reset release
      // erased fields read as the divided fast rc code
      // select and mode together give the clock mode
      cfgLoaded_q <= 1'b1;
      curOsc_q <= initialOscSelect;
      newOsc_q <= initialOscSelect;
      primaryMode_q <= primaryOscModeSelect;
    end else begin
      if (wrCtrl) begin
        clockLock_q <= pwdata[CLOCK_LOCK_BIT];
        lowPowerOscEn_q <= pwdata[LP_OSC_EN_BIT];
        if (!pwdata[CLOCK_FAIL_BIT]) begin
          clockFail_q <= 1'b0;
        end
        if (switchReq) begin
          newOsc_q <= pwdata[NEW_OSC_LSB +: 3];
          oscSwitch_q <= 1'b1;
        end
      end
      case (swState_q)
        SW_IDLE: begin
          if (switchReq) begin
            swState_q <= SW_WAIT_SRC;
          end
        end
        SW_WAIT_SRC: begin
          if (newReady) begin
            swState_q <= SW_WAIT_LOW;
          end
        end
        SW_WAIT_LOW: begin
          // change over only on a tick with the clock low
          if (curTick && !instrClk_q) begin
            curOsc_q <= newOsc_q;
            oscSwitch_q <= 1'b0;
            swState_q <= SW_IDLE;
          end
        end
        default: begin
          swState_q <= SW_IDLE;
        end
      endcase
      // fail-safe fallback wins over any pending switch
      if (failEvent) begin
        clockFail_q <= 1'b1;
        curOsc_q <= SEL_FAST_RC;
        newOsc_q <= SEL_FAST_RC;
        oscSwitch_q <= 1'b0;
        swState_q <= SW_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // instruction and peripheral clocks
  // ----------------------------------------------------------------
  logic periphClk_q;
  logic [6:0] dozeCnt_q;
  logic [6:0] dozeMask;
  logic periphToggle;

  // doze toggles the peripheral clock once per mask+1 instruction edges
  assign dozeMask = 7'((8'h01 << div_q.dozeRatio) - 8'h01);
  assign periphToggle = curTick & (~div_q.dozeEn | ((dozeCnt_q & dozeMask) == dozeMask));

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      instrClk_q <= 1'b0;
      periphClk_q <= 1'b0;
      dozeCnt_q <= 7'h00;
    end else begin
      // one toggle per oscillator edge halves the rate
      // ceiling set by the tick rate of the selected source
      if (curTick) begin
        instrClk_q <= ~instrClk_q;
        dozeCnt_q <= dozeCnt_q + 7'h01;
      end
      if (periphToggle) begin
        periphClk_q <= ~periphClk_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers and reference outputs
  // ----------------------------------------------------------------
  logic primaryOut_q;
  logic primaryOutEn_q;
  logic secondaryOut_q;
  logic secondaryOutEn_q;
  logic pllRefTick_q;
  logic watchdogRefTick_q;
  logic primaryUsed;

  assign primaryUsed = (curOsc_q == SEL_PRIMARY) || (curOsc_q == SEL_PRIMARY_PLL)
                       || (newOsc_q == SEL_PRIMARY) || (newOsc_q == SEL_PRIMARY_PLL);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      primaryOut_q <= 1'b0;
      primaryOutEn_q <= 1'b0;
      secondaryOut_q <= 1'b0;
      secondaryOutEn_q <= 1'b0;
      pllRefTick_q <= 1'b0;
      watchdogRefTick_q <= 1'b0;
    end else begin
      // crystal driver runs in every primary mode code except external clock
      primaryOutEn_q <= primaryUsed && (primaryMode_q != MODE_EXTERNAL);
      primaryOut_q <= ~syncB_q[0];
      secondaryOutEn_q <= secondaryRun;
      secondaryOut_q <= ~syncB_q[1];
      // pll reference from fast rc or primary only
      pllRefTick_q <= (newOsc_q == SEL_FAST_RC_PLL) ? frcTick
                    : (newOsc_q == SEL_PRIMARY_PLL) ? primaryTick : 1'b0;
      // low-power rc tick also paces the watchdog
      watchdogRefTick_q <= lprcTick;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign primaryOscOutPin = primaryOut_q;
  assign primaryOscOutEn = primaryOutEn_q;
  assign secondaryOscOutPin = secondaryOut_q;
  assign secondaryOscOutEn = secondaryOutEn_q;
  assign pllRefTick = pllRefTick_q;
  assign instrClk = instrClk_q;
  assign peripheralClk = periphClk_q;
  assign watchdogRefTick = watchdogRefTick_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  instr_half_rate_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      curTick |=> (instrClk_q != $past(instrClk_q)))
    else $error("instruction clock missed an oscillator edge");
  periph_follow_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      (!div_q.dozeEn && curTick) |=> (periphClk_q != $past(periphClk_q)))
    else $error("peripheral clock left instruction clock outside doze");
  pll_ref_src_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      pllRefTick_q |-> ($past(newOsc_q) == SEL_FAST_RC_PLL
                        || $past(newOsc_q) == SEL_PRIMARY_PLL))
    else $error("pll fed from a source that bypasses it");
  fail_fallback_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      failEvent |=> (curOsc_q == SEL_FAST_RC) && clockFail_q && !oscSwitch_q)
    else $error("clock fail did not fall back to fast rc");
  no_runt_switch_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      ($past(cfgLoaded_q) && !$past(failEvent) && curOsc_q != $past(curOsc_q))
        |-> !$past(instrClk_q) && $past(swState_q) == SW_WAIT_LOW)
    else $error("source changed outside a low phase");
  pll_hop_block_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      (wrCtrl && illegalSwitch && !oscSwitch_q) |=> !oscSwitch_q)
    else $error("direct pll to pll switch was accepted");
  switch_start_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      switchReq && !failEvent |=> oscSwitch_q && swState_q == SW_WAIT_SRC)
    else $error("switch request not started");
  watchdog_ref_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      lprcTick |=> watchdogRefTick_q ##1 !watchdogRefTick_q)
    else $error("watchdog reference tick lost");
  postscale_rate_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      (frcDivTick && div_q.postscale == 3'h0) |-> postCnt_q[0])
    else $error("postscaler divided by the wrong factor");
  apb_answer_a:
    assert property (@(posedge ref_clk) disable iff (reset)
      (psel && penable && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("register access answer not one cycle");

endmodule

// ==== verif/tb_top.sv ====
// self-checking bench of the system clock source select block
module tb_top import scs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic primaryOscInPin, secondaryOscInPin, pllClkIn, pllLockIn, secOn;
  logic instrClk, peripheralClk;
  logic [7:0] cnt;
  logic [2:0] initSel;
  logic [1:0] modeSel;
  logic priOutEn, secOutEn, wdTick, pllRef;
  int nw, nr;
  int num_errors = 0;
  int check_count = 0;

  scs_clock_select dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .initialOscSelect(initSel), .primaryOscModeSelect(modeSel),
    .primaryOscInPin(primaryOscInPin), .primaryOscOutPin(), .primaryOscOutEn(priOutEn),
    .secondaryOscInPin(secondaryOscInPin), .secondaryOscOutPin(),
    .secondaryOscOutEn(secOutEn),
    .pllClkIn(pllClkIn), .pllLockIn(pllLockIn), .pllRefTick(pllRef),
    .instrClk(instrClk), .peripheralClk(peripheralClk), .watchdogRefTick(wdTick)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // oscillator inputs stepped from a free counter; secondary can be stopped
  always @(posedge ref_clk) begin
    cnt <= cnt + 8'h01;
    primaryOscInPin <= cnt[1];
    pllClkIn <= cnt[0];
    if (secOn) begin
      secondaryOscInPin <= cnt[3];
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
    @(posedge ref_clk);
  endtask

  task automatic poll(input logic [31:0] mask, input logic [31:0] want);
    int n;
    n = 0;
    do begin
      apb(1'b0, OSC_CTRL_OFS, 32'h0);
      n++;
    end while ((rdv & mask) !== want && n < 1500);
    chk(rdv & mask, want);
    if ((rdv & mask) !== want) print_verdict();
  endtask

  task automatic count(output int ni, output int np);
    logic li, lp;
    ni = 0;
    np = 0;
    nw = 0;
    nr = 0;
    li = instrClk;
    lp = peripheralClk;
    repeat (2000) begin
      @(posedge ref_clk);
      if (instrClk !== li) ni++;
      if (peripheralClk !== lp) np++;
      if (wdTick === 1'b1) nw++;
      if (pllRef === 1'b1) nr++;
      li = instrClk;
      lp = peripheralClk;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, OSC_CTRL_OFS, 32'h0);
    chk(rdv, 32'h0000_7700);
    apb(1'b0, CLK_DIV_OFS, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, RC_TUNE_OFS, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b1, 12'h00c, 32'hffff_ffff);
    chk({31'h0, errv}, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk({errv, rdv[30:0]}, 32'h8000_0000);
  endtask

  task automatic t_divider();
    int c0, p0, c2, p2, c3, p3;
    count(c0, p0);
    chk(32'(p0), 32'(c0));
    chk(32'(nw >= 6 && nw <= 7), 32'h1);
    apb(1'b1, CLK_DIV_OFS, 32'h0000_1a00);
    apb(1'b0, CLK_DIV_OFS, 32'h0);
    chk(rdv, 32'h0000_1a00);
    count(c2, p2);
    chk(32'(c2 * 4 > c0 - 12 && c2 * 4 < c0 + 12), 32'h1);
    chk(32'(p2 * 2 > c2 - 3 && p2 * 2 < c2 + 3), 32'h1);
    apb(1'b1, RC_TUNE_OFS, 32'h0000_001f);
    count(c3, p3);
    chk(32'(c3 > c2), 32'h1);
    apb(1'b1, RC_TUNE_OFS, 32'h0);
  endtask

  task automatic t_switch();
    int c, p;
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0201);
    poll(32'h0000_7001, 32'h0000_2000);
    count(c, p);
    chk(32'(c > 497 && c < 503), 32'h1);
    chk(32'(nr), 32'h0);
    chk({31'h0, priOutEn}, 32'h1);
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0001);
    poll(32'h0000_7001, 32'h0);
    chk({31'h0, priOutEn}, 32'h0);
    pllLockIn <= 1'b1;
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0101);
    poll(32'h0000_7021, 32'h0000_1020);
    count(c, p);
    chk(32'(nr > 1471 && nr < 1477), 32'h1);
    chk(32'(c > 997 && c < 1003), 32'h1);
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0301);
    repeat (100) @(posedge ref_clk);
    apb(1'b0, OSC_CTRL_OFS, 32'h0);
    chk(rdv & 32'h0000_7000, 32'h0000_1000);
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0001);
    poll(32'h0000_7001, 32'h0);
  endtask

  task automatic t_fail();
    secOn <= 1'b1;
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0403);
    poll(32'h0000_7001, 32'h0000_4000);
    chk({31'h0, secOutEn}, 32'h1);
    secOn <= 1'b0;
    poll(32'h0000_7008, 32'h0000_0008);
    apb(1'b1, OSC_CTRL_OFS, 32'h0);
    apb(1'b0, OSC_CTRL_OFS, 32'h0);
    chk(rdv & 32'h0000_7008, 32'h0);
    chk({31'h0, secOutEn}, 32'h0);
  endtask

  task automatic t_cfg();
    int c, p;
    reset <= 1'b1;
    initSel <= SEL_PRIMARY;
    modeSel <= MODE_EXTERNAL;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    apb(1'b0, OSC_CTRL_OFS, 32'h0);
    chk(rdv & 32'h0000_7701, 32'h0000_2200);
    chk({31'h0, priOutEn}, 32'h0);
    count(c, p);
    chk(32'(c > 497 && c < 503), 32'h1);
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0080);
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0601);
    repeat (20) @(posedge ref_clk);
    apb(1'b0, OSC_CTRL_OFS, 32'h0);
    chk(rdv & 32'h0000_7001, 32'h0000_2000);
    apb(1'b1, OSC_CTRL_OFS, 32'h0000_0601);
    poll(32'h0000_7001, 32'h0000_6000);
    count(c, p);
    chk(32'(c > 89 && c < 95), 32'h1);
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cnt = 8'h00;
    secOn = 1'b0;
    secondaryOscInPin = 1'b0;
    primaryOscInPin = 1'b0;
    pllClkIn = 1'b0;
    pllLockIn = 1'b0;
    initSel = SEL_FAST_RC_DIVN;
    modeSel = MODE_CRYSTAL;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    t_reset();
    t_divider();
    t_switch();
    t_fail();
    t_cfg();
    print_verdict();
  end
endmodule
